// ===== hdl/udp_regs.svh
// Purpose : Offsets, field positions and reset values of the serial data port
// Assumes : Byte addressing on a 32-bit Avalon-MM slave, one word per register
// Notes   : Definitions only; include by bare name

`ifndef UDP_REGS_SVH
`define UDP_REGS_SVH

// Register byte offsets
`define UDP_ADDR_DATA       4'h0
`define UDP_ADDR_STAT       4'h4
`define UDP_ADDR_MASK       4'h8
`define UDP_ADDR_CTRL       4'hC

// Data window field positions
`define UDP_DATA_NOISE      15
`define UDP_DATA_PARERR     14
`define UDP_DATA_FRAME      13
`define UDP_DATA_VOID       12
`define UDP_DATA_QUIET      11
`define UDP_DATA_TOP        9
`define UDP_DATA_BIT8       8
`define UDP_DATA_BIT7       7

// Control field positions
`define UDP_CTRL_PARITY_ON  0
`define UDP_CTRL_PARITY_ODD 1
`define UDP_CTRL_NINE_BIT   2

// Interrupt status and mask field positions
`define UDP_IRQ_RX_ARRIVE   0
`define UDP_IRQ_RX_ERROR    1
`define UDP_IRQ_TX_FREE     2

// Reset values
`define UDP_CTRL_RST        3'h0
`define UDP_MASK_RST        3'h0
`define UDP_STAT_RST        3'h0
`define UDP_RDATA_RST       32'h00000000
`define UDP_CHAR_RST        10'h000

`endif

// ===== hdl/udp_pkg.sv
// Purpose : Types shared by the serial data port files
// Assumes : Nothing is imported; users write udp_pkg::name
// Notes   : All state of the top module lives in one packed struct

package udp_pkg;

    // Bus answer sequencer, Gray coded along idle -> answer -> idle
    typedef enum logic [1:0] {
        udp_st_idle   = 2'b00,
        udp_st_answer = 2'b01
    } udp_bus_st_t;

    // Complete register state of the data port
    typedef struct packed {
        udp_bus_st_t bus_st;
        logic        waitreq;
        logic [31:0] rdata;
        logic        rx_full;
        logic        rx_ready;
        logic [9:0]  rx_data;
        logic        rx_noise_flag;
        logic        rx_parity_error;
        logic        rx_frame_err;
        logic        line_quiet_before_char;
        logic        tx_full;
        logic [9:0]  tx_data;
        logic        tx_special;
        logic        tx_idle_char;
        logic        parity_on;
        logic        parity_odd;
        logic        nine_bit;
        logic [2:0]  irq_stat;
        logic [2:0]  irq_mask;
        logic        irq;
    } udp_state_t;

endpackage

// ===== hdl/udp_parity.sv
// Purpose : Parity value of a character, for generation and for checking
// Assumes : Parity bit sits just before the stop bit: bit 8 in nine-bit mode,
//           bit 7 otherwise
// Notes   : Purely combinational; the same logic serves transmit and receive

`timescale 1ns/1ns

module udp_parity (
    // Character and format
    input  wire logic [9:0] i_data,
    input  wire logic       i_nine_bit,
    input  wire logic       i_odd,
    // Parity bit that belongs in the parity position
    output logic            o_parity
);

    // Fold only the bits below the parity position
    always_comb begin
        if (i_nine_bit) begin
            o_parity = (^i_data[7:0]) ^ i_odd;
        end else begin
            o_parity = (^i_data[6:0]) ^ i_odd;
        end
    end

endmodule

// ===== hdl/udp_data_port.sv
// Purpose : Data register port of an asynchronous serial transceiver
// Assumes : Receive and transmit buffer handshakes come from logic on i_clk;
//           baud generation and shifting live outside this block
// Notes   : Avalon-MM slave with registered waitrequest and readdata;
//           a data write waits while the transmit buffer is still occupied
//
// Notes on behaviour
// - One address reads the receive buffer and writes the transmit buffer.
// - Data window reads and writes clear the related interrupt status bits.
// - Bits 31 to 16 and bit 10 of the data window read as zero.
// - Bit 15 on read tells whether the held character was sampled with noise.
// - Bit 14 on read tells whether the held character failed its parity check.
// - Bit 13 on read tells whether the held character had a bad stop bit.
// - Bit 13 set on write sends a special character instead of the data bits.
// - A special character is a break when bit 9 is 0 and an idle when it is 1.
// - Bit 12 on read is set while the receive buffer holds no character.
// - Bit 11 on read tells that the line was idle before the held character.
// - Bits 9 to 0 carry the character bit for bit on read and on write.
// - With parity on, the bit just before the stop bit is the parity bit.
//
// Decided for this implementation: the register offsets and the Avalon-MM slave port.

`timescale 1ns/1ns

`include "udp_regs.svh"

module udp_data_port (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    // Avalon-MM slave
    input  wire logic [3:0]  i_address,
    input  wire logic        i_read,
    input  wire logic        i_write,
    input  wire logic [3:0]  i_byteenable,
    input  wire logic [31:0] i_writedata,
    output logic [31:0]      o_readdata,
    output logic             o_waitrequest,
    // Interrupt
    output logic             o_irq,
    // Receive buffer handshake from the receive shifter
    input  wire logic        i_rx_valid,
    input  wire logic [9:0]  i_rx_data,
    input  wire logic        i_rx_noise,
    input  wire logic        i_rx_frame_err,
    input  wire logic        i_rx_line_quiet,
    output logic             o_rx_ready,
    // Transmit buffer handshake to the transmit shifter
    output logic             o_tx_valid,
    output logic [9:0]       o_tx_data,
    output logic             o_tx_special,
    output logic             o_tx_idle_char,
    input  wire logic        i_tx_ready
);

    // Reset image of the whole state
    localparam udp_pkg::udp_state_t STATE_RST = '{
        bus_st                 : udp_pkg::udp_st_idle,
        waitreq                : 1'b1,
        rdata                  : `UDP_RDATA_RST,
        rx_full                : 1'b0,
        rx_ready               : 1'b1,
        rx_data                : `UDP_CHAR_RST,
        rx_noise_flag          : 1'b0,
        rx_parity_error        : 1'b0,
        rx_frame_err           : 1'b0,
        line_quiet_before_char : 1'b0,
        tx_full                : 1'b0,
        tx_data                : `UDP_CHAR_RST,
        tx_special             : 1'b0,
        tx_idle_char           : 1'b0,
        parity_on              : 1'b0,
        parity_odd             : 1'b0,
        nine_bit               : 1'b0,
        irq_stat               : `UDP_STAT_RST,
        irq_mask               : `UDP_MASK_RST,
        irq                    : 1'b0
    };

    udp_pkg::udp_state_t state_q;
    udp_pkg::udp_state_t state_d;

    logic        req_seen;
    logic        is_data;
    logic        do_read;
    logic        do_write;
    logic        rd_pop;
    logic        rx_take;
    logic        tx_hand;
    logic [15:0] wr_low;
    logic        wr_special;
    logic        tx_par_bit;
    logic        rx_par_bit;
    logic        rx_par_seen;
    logic        rx_perr;
    logic [9:0]  tx_word;
    logic [31:0] rd_word;
    logic [31:0] data_word;

    // A request is taken only while idle with waitrequest high, so the held
    // request of the answer cycle is never taken twice
    assign req_seen = (i_read | i_write) & state_q.waitreq
                      & (state_q.bus_st == udp_pkg::udp_st_idle);
    assign is_data  = (i_address == `UDP_ADDR_DATA);

    // Data writes stall while the transmit buffer is occupied; the master
    // sees waitrequest high until the shifter takes the pending character
    assign do_write = req_seen & i_write & ~i_read & (~is_data | ~state_q.tx_full);
    assign do_read  = req_seen & i_read & ~i_write;

    // Only a read that finds a character pops it
    assign rd_pop   = do_read & is_data & state_q.rx_full;

    // Buffer handshakes with the shifters
    assign rx_take  = i_rx_valid & state_q.rx_ready;
    assign tx_hand  = state_q.tx_full & i_tx_ready;

    // Write data of the two low byte lanes; a lane not enabled writes zero
    assign wr_low[7:0]  = i_byteenable[0] ? i_writedata[7:0] : 8'h00;
    assign wr_low[15:8] = i_byteenable[1] ? i_writedata[15:8] : 8'h00;
    assign wr_special   = wr_low[`UDP_DATA_FRAME];

    // Two copies, so transmit and receive parity never share a path
    // Parity generation on the written character
    udp_parity u_tx_parity (
        .i_data     (wr_low[9:0]),
        .i_nine_bit (state_q.nine_bit),
        .i_odd      (state_q.parity_odd),
        .o_parity   (tx_par_bit)
    );

    // Parity check on the arriving character
    udp_parity u_rx_parity (
        .i_data     (i_rx_data),
        .i_nine_bit (state_q.nine_bit),
        .i_odd      (state_q.parity_odd),
        .o_parity   (rx_par_bit)
    );

    // The received parity bit sits just before the stop bit
    assign rx_par_seen = state_q.nine_bit ? i_rx_data[`UDP_DATA_BIT8]
                                          : i_rx_data[`UDP_DATA_BIT7];
    assign rx_perr     = state_q.parity_on & (rx_par_seen != rx_par_bit);

    // Character handed to the shifter; special characters pass untouched,
    // since their bits only select break or idle
    always_comb begin
        tx_word = wr_low[9:0];
        if (~wr_special && state_q.parity_on) begin
            if (state_q.nine_bit) begin
                tx_word[`UDP_DATA_BIT8] = tx_par_bit;
            end else begin
                tx_word[`UDP_DATA_BIT7] = tx_par_bit;
            end
        end
    end

    // Read image of the data window; unlisted bits stay zero
    always_comb begin
        data_word                   = 32'h00000000;
        data_word[9:0]              = state_q.rx_data;
        data_word[`UDP_DATA_NOISE]  = state_q.rx_noise_flag;
        data_word[`UDP_DATA_PARERR] = state_q.rx_parity_error;
        data_word[`UDP_DATA_FRAME]  = state_q.rx_frame_err;
        data_word[`UDP_DATA_VOID]   = ~state_q.rx_full;
        data_word[`UDP_DATA_QUIET]  = state_q.line_quiet_before_char;
    end

    // Read multiplexer; an unmapped offset reads zero
    // Decoded from the live address, so the image is that of the taking edge
    always_comb begin
        rd_word = 32'h00000000;
        case (i_address)
            `UDP_ADDR_DATA: begin
                rd_word = data_word;
            end
            `UDP_ADDR_STAT: begin
                rd_word[2:0] = state_q.irq_stat;
            end
            `UDP_ADDR_MASK: begin
                rd_word[2:0] = state_q.irq_mask;
            end
            `UDP_ADDR_CTRL: begin
                rd_word[`UDP_CTRL_PARITY_ON]  = state_q.parity_on;
                rd_word[`UDP_CTRL_PARITY_ODD] = state_q.parity_odd;
                rd_word[`UDP_CTRL_NINE_BIT]   = state_q.nine_bit;
            end
            default: begin
                rd_word = 32'h00000000;
            end
        endcase
    end

    // Next state of the whole port; clears are applied before sets so that
    // an event landing in the clearing cycle survives
    always_comb begin
        state_d = state_q;

        // Bus answer: one cycle of waitrequest low with the read data
        case (state_q.bus_st)
            udp_pkg::udp_st_idle: begin
                if (do_read || do_write) begin
                    state_d.bus_st  = udp_pkg::udp_st_answer;
                    state_d.waitreq = 1'b0;
                    state_d.rdata   = do_read ? rd_word : state_q.rdata;
                end
            end
            udp_pkg::udp_st_answer: begin
                state_d.bus_st  = udp_pkg::udp_st_idle;
                state_d.waitreq = 1'b1;
            end
            default: begin
                state_d.bus_st  = udp_pkg::udp_st_idle;
                state_d.waitreq = 1'b1;
            end
        endcase

        // Reading a held character frees the buffer and its status
        if (rd_pop) begin
            state_d.rx_full                      = 1'b0;
            state_d.irq_stat[`UDP_IRQ_RX_ARRIVE] = 1'b0;
            state_d.irq_stat[`UDP_IRQ_RX_ERROR]  = 1'b0;
        end

        // Register writes; status, mask and control take lane 0 only,
        // so a wider write never disturbs them
        if (do_write) begin
            case (i_address)
                `UDP_ADDR_DATA: begin
                    state_d.tx_full                    = 1'b1;
                    state_d.tx_data                    = tx_word;
                    state_d.tx_special                 = wr_special;
                    state_d.tx_idle_char               = wr_special
                                                         & wr_low[`UDP_DATA_TOP];
                    state_d.irq_stat[`UDP_IRQ_TX_FREE] = 1'b0;
                end
                `UDP_ADDR_STAT: begin
                    state_d.irq_stat = state_d.irq_stat & ~wr_low[2:0];
                end
                `UDP_ADDR_MASK: begin
                    state_d.irq_mask = wr_low[2:0];
                end
                `UDP_ADDR_CTRL: begin
                    state_d.parity_on  = wr_low[`UDP_CTRL_PARITY_ON];
                    state_d.parity_odd = wr_low[`UDP_CTRL_PARITY_ODD];
                    state_d.nine_bit   = wr_low[`UDP_CTRL_NINE_BIT];
                end
                default: begin
                    state_d.irq_mask = state_d.irq_mask;
                end
            endcase
        end

        // Shifter takes the pending character; cannot meet a data write,
        // which needs the buffer empty
        if (tx_hand) begin
            state_d.tx_full                    = 1'b0;
            state_d.irq_stat[`UDP_IRQ_TX_FREE] = 1'b1;
        end

        // Only one character is held; the shifter must keep offering while
        // the buffer is full, since nothing here can store a second one
        // A new character enters only an empty buffer, so nothing is lost
        if (rx_take) begin
            state_d.rx_full                = 1'b1;
            state_d.rx_data                = i_rx_data;
            state_d.rx_noise_flag          = i_rx_noise;
            state_d.rx_parity_error        = rx_perr;
            state_d.rx_frame_err           = i_rx_frame_err;
            state_d.line_quiet_before_char = i_rx_line_quiet;
            state_d.irq_stat[`UDP_IRQ_RX_ARRIVE] = 1'b1;
            if (i_rx_noise || rx_perr || i_rx_frame_err) begin
                state_d.irq_stat[`UDP_IRQ_RX_ERROR] = 1'b1;
            end
        end

        // Ready and interrupt are registered images of the next state
        state_d.rx_ready = ~state_d.rx_full;
        state_d.irq      = |(state_d.irq_stat & state_d.irq_mask);
    end

    // State register; reset needs no clock, every field loads a constant
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_q <= STATE_RST;
        end else begin
            state_q <= state_d;
        end
    end

    // Outputs straight from the state register
    assign o_readdata     = state_q.rdata;
    assign o_waitrequest  = state_q.waitreq;
    assign o_irq          = state_q.irq;
    assign o_rx_ready     = state_q.rx_ready;
    assign o_tx_valid     = state_q.tx_full;
    assign o_tx_data      = state_q.tx_data;
    assign o_tx_special   = state_q.tx_special;
    assign o_tx_idle_char = state_q.tx_idle_char;

endmodule

// ===== tb/udp_data_port_sva.sv
// Purpose : Pin-level checks of the serial data port
// Assumes : Data writes use all four byte lanes
// Notes   : Bound to every udp_data_port instance

`timescale 1ns/1ns

module udp_data_port_sva (
    // Clock, reset and bus
    input wire logic        i_clk,
    input wire logic        i_resetn,
    input wire logic [3:0]  i_address,
    input wire logic        i_read,
    input wire logic        i_write,
    input wire logic [3:0]  i_byteenable,
    input wire logic [31:0] i_writedata,
    input wire logic [31:0] o_readdata,
    input wire logic        o_waitrequest,
    input wire logic        o_irq,
    // Buffer handshakes
    input wire logic        i_rx_valid,
    input wire logic [9:0]  i_rx_data,
    input wire logic        i_rx_noise,
    input wire logic        i_rx_frame_err,
    input wire logic        i_rx_line_quiet,
    input wire logic        o_rx_ready,
    input wire logic        o_tx_valid,
    input wire logic [9:0]  o_tx_data,
    input wire logic        o_tx_special,
    input wire logic        o_tx_idle_char,
    input wire logic        i_tx_ready
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);

    // Answer cycles of the data window
    sequence data_rd_s;
        !o_waitrequest && i_read && i_address == 4'h0;
    endsequence
    sequence data_wr_s;
        !o_waitrequest && i_write && i_address == 4'h0 && i_byteenable == 4'hF;
    endsequence

    // A stuck-low waitrequest would double every access
    ans_pulse_a: assert property (!o_waitrequest |=> o_waitrequest)
        else $error("waitrequest low longer than one cycle");
    rsv_zero_a: assert property (!o_waitrequest && i_read |->
        o_readdata[31:16] == 16'h0000 && !o_readdata[10])
        else $error("reserved read bits not zero");
    void_bit_a: assert property (data_rd_s |-> o_readdata[12] == $past(o_rx_ready))
        else $error("empty bit disagrees with buffer state");
    pop_read_a: assert property (data_rd_s ##0 !o_readdata[12] |-> o_rx_ready)
        else $error("read of a full buffer did not free it");
    empty_keep_a: assert property (data_rd_s ##0 o_readdata[12] && !$past(i_rx_valid)
        |-> o_rx_ready)
        else $error("empty read changed buffer state");
    rx_take_a: assert property (i_rx_valid && o_rx_ready |=> !o_rx_ready)
        else $error("received character not held");
    tx_take_a: assert property (o_tx_valid && i_tx_ready |=> !o_tx_valid)
        else $error("transmit buffer not freed after take");
    tx_load_a: assert property (data_wr_s |-> o_tx_valid && o_tx_special == i_writedata[13]
        && (!i_writedata[13] || o_tx_idle_char == i_writedata[9]))
        else $error("transmit buffer load wrong");
    tx_stall_a: assert property (i_write && i_address == 4'h0 && o_waitrequest && o_tx_valid
        |=> o_waitrequest)
        else $error("data write answered while buffer full");
endmodule

bind udp_data_port udp_data_port_sva udp_data_port_sva_inst (.*);

// ===== tb/udp_shifter_model.sv
// Purpose : Behavioural stand-in for the receive and transmit shifters
// Assumes : Bench calls offer for each received character
// Notes   : Released receive lines carry the inverse of the last value

`timescale 1ns/1ns

module udp_shifter_model (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_resetn,
    // Receive side offered to the port
    output logic            o_rx_valid,
    output logic [9:0]      o_rx_data,
    output logic            o_rx_noise,
    output logic            o_rx_frame_err,
    output logic            o_rx_line_quiet,
    input  wire logic       i_rx_ready,
    // Transmit side taken from the port
    input  wire logic       i_tx_valid,
    input  wire logic [9:0] i_tx_data,
    input  wire logic       i_tx_special,
    input  wire logic       i_tx_idle_char,
    output logic            o_tx_ready,
    // Slow shifter request from the bench
    input  wire logic       i_stall
);
    logic [11:0] log_q[$];

    // Idle receive side at time zero
    initial begin
        o_rx_valid = 1'b0;
        {o_rx_noise, o_rx_frame_err, o_rx_line_quiet, o_rx_data} = 13'h0000;
    end

    // Offer {noise, frame, quiet, char} and hold it until taken
    task automatic offer(input logic [12:0] c);
        @(posedge i_clk);
        o_rx_valid <= 1'b1;
        {o_rx_noise, o_rx_frame_err, o_rx_line_quiet, o_rx_data} <= c;
        do @(posedge i_clk); while (i_rx_ready !== 1'b1);
        o_rx_valid <= 1'b0;
        {o_rx_noise, o_rx_frame_err, o_rx_line_quiet, o_rx_data} <= ~c;
    endtask

    // Take pending characters unless stalled; log {special, idle, char}
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_tx_ready <= 1'b0;
        end else begin
            o_tx_ready <= !i_stall;
            if (i_tx_valid && o_tx_ready) log_q.push_back({i_tx_special, i_tx_idle_char, i_tx_data});
        end
    end
endmodule

// ===== tb/tb.sv
// Purpose : Self-checking bench of the serial data port
// Assumes : Bus tasks wait for waitrequest low, one request at a time
// Notes   : Control 1 is 8-bit even parity, 3 is 8-bit odd parity, 5 nine-bit even parity

`timescale 1ns/1ns

module tb;
    // Bench signals
    logic        i_clk, i_resetn, i_read, i_write, stall;
    logic        o_waitrequest, o_irq, o_rx_ready, o_tx_valid, o_tx_special, o_tx_idle_char;
    logic        rx_valid, rx_noise, rx_frame, rx_quiet, tx_ready;
    logic [3:0]  i_address;
    logic [9:0]  rx_data, o_tx_data;
    logic [31:0] i_writedata, o_readdata, rd;
    logic [12:0] c;
    logic [11:0] m;
    logic [12:0] rx_tab[4] = '{13'h16A5, 13'h0BFF, 13'h0000, 13'h1D55};
    logic [11:0] tx_tab[5] = '{12'h155, 12'h800, 12'hC00, 12'h081, 12'h101};
    int          failures, tests_run, cycles;

    udp_data_port udp_data_port_inst (.i_clk(i_clk), .i_resetn(i_resetn),
        .i_address(i_address), .i_read(i_read), .i_write(i_write), .i_byteenable(4'hF),
        .i_writedata(i_writedata), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
        .o_irq(o_irq), .i_rx_valid(rx_valid), .i_rx_data(rx_data), .i_rx_noise(rx_noise),
        .i_rx_frame_err(rx_frame), .i_rx_line_quiet(rx_quiet), .o_rx_ready(o_rx_ready),
        .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data), .o_tx_special(o_tx_special),
        .o_tx_idle_char(o_tx_idle_char), .i_tx_ready(tx_ready));

    udp_shifter_model udp_shifter_model_inst (.i_clk(i_clk), .i_resetn(i_resetn),
        .o_rx_valid(rx_valid), .o_rx_data(rx_data), .o_rx_noise(rx_noise),
        .o_rx_frame_err(rx_frame), .o_rx_line_quiet(rx_quiet), .i_rx_ready(o_rx_ready),
        .i_tx_valid(o_tx_valid), .i_tx_data(o_tx_data), .i_tx_special(o_tx_special),
        .i_tx_idle_char(o_tx_idle_char), .o_tx_ready(tx_ready), .i_stall(stall));

    // 10 MHz clock
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end

    task automatic chk(input string what, input logic [31:0] exp, got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One bus access; request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clk);
        i_address <= a;
        i_writedata <= d;
        i_write <= wr;
        i_read <= !wr;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_waitrequest !== 1'b0 && n < 500);
        rd = o_readdata;
        i_read <= 1'b0;
        i_write <= 1'b0;
        if (n >= 500) begin
            failures++;
            tally_and_finish;
        end
    endtask

    task automatic rchk(input logic [3:0] a, input logic [31:0] msk, exp, input string what);
        bus(1'b0, a, 32'h00000000);
        chk(what, exp, rd & msk);
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            tally_and_finish;
        end
    end

    initial begin
        {i_resetn, i_read, i_write, stall} = 4'h0;
        i_address = 4'h0;
        i_writedata = 32'h00000000;
        repeat (12) @(posedge i_clk);
        chk("reset outputs", 32'hA, {28'h0, o_waitrequest, o_irq, o_rx_ready, o_tx_valid});
        i_resetn <= 1'b1;
        bus(1'b1, 4'h1, 32'hFFFFFFFF);
        for (int a = 1; a < 16; a += 4) begin
            rchk(a[3:0] + 4'h3, 32'hFFFFFFFF, (a == 13) ? 32'h00001000 : 32'h0,
                "reset reg");
        end
        rchk(4'h1, 32'hFFFFFFFF, 32'h0, "unmapped");
        rchk(4'h0, 32'hFFFF1400, 32'h00001000, "empty image");
        // Receive with every status flag combination in the table
        bus(1'b1, 4'h8, 32'h3);
        for (int i = 0; i < 4; i++) begin
            c = rx_tab[i];
            udp_shifter_model_inst.offer(c);
            rchk(4'h4, 32'h3, {30'h0, c[12] | c[11], 1'b1}, "arrive status");
            chk("irq raised", 32'h1, {31'h0, o_irq});
            rchk(4'h0, 32'hFFFFFFFF, {16'h0, c[12], 1'b0, c[11], 1'b0, c[10], 1'b0, c[9:0]},
                "rx image");
            rchk(4'h4, 32'h3, 32'h0, "popped status");
            chk("irq after pop", 32'h0, {31'h0, o_irq});
        end
        rchk(4'h0, 32'hFFFF1400, 32'h00001000, "empty again");
        rchk(4'h4, 32'h3, 32'h0, "empty status");
        // Receive parity check at bit 7
        bus(1'b1, 4'hC, 32'h1);
        for (int i = 0; i < 4; i++) begin
            if (i == 2) bus(1'b1, 4'hC, 32'h3);
            c = i[0] ? 13'h0003 : 13'h0083;
            udp_shifter_model_inst.offer(c);
            rchk(4'h0, 32'h4000, {17'h0, (^c[7:0]) ^ i[1], 14'h0}, "rx parity");
        end
        // Transmit normal, break, idle and parity characters, shifter slow at first
        bus(1'b1, 4'hC, 32'h0);
        bus(1'b1, 4'h8, 32'h0);
        stall <= 1'b1;
        bus(1'b1, 4'h0, 32'h155);
        fork
            bus(1'b1, 4'h0, 32'h2000);
            begin
                repeat (6) @(posedge i_clk);
                chk("stalled write", 32'h1, {31'h0, o_waitrequest});
                stall <= 1'b0;
            end
        join
        bus(1'b1, 4'h0, 32'h2200);
        bus(1'b1, 4'hC, 32'h1);
        bus(1'b1, 4'h0, 32'h1);
        bus(1'b1, 4'hC, 32'h5);
        bus(1'b1, 4'h0, 32'h1);
        repeat (6) @(posedge i_clk);
        chk("tx count", 32'd5, 32'(udp_shifter_model_inst.log_q.size()));
        for (int i = 0; i < 5 && i < udp_shifter_model_inst.log_q.size(); i++) begin
            m = tx_tab[i][11] ? 12'hC00 : 12'hFFF;
            chk("tx char", {20'h0, tx_tab[i] & m},
                {20'h0, udp_shifter_model_inst.log_q[i] & m});
        end
        // Transmit-free interrupt: masked, unmasked, cleared by writing one
        chk("irq masked", 32'h0, {31'h0, o_irq});
        bus(1'b1, 4'h8, 32'h4);
        rchk(4'h4, 32'h4, 32'h4, "tx free status");
        chk("irq unmasked", 32'h1, {31'h0, o_irq});
        bus(1'b1, 4'h4, 32'h4);
        rchk(4'h4, 32'h4, 32'h0, "tx free cleared");
        chk("irq cleared", 32'h0, {31'h0, o_irq});
        tally_and_finish;
    end
endmodule
